/* dcrc_defines.vh */
// constants for the dma crc and checksum engine
`ifndef DCRC_DEFINES_VH
`define DCRC_DEFINES_VH

// register byte addresses on the axi4-lite bus
`define DCRC_OFF_CTRL      8'h00
`define DCRC_OFF_DATA      8'h04
`define DCRC_OFF_TAPS      8'h08

// control register field positions
`define DCRC_ORDER_HI      29
`define DCRC_ORDER_LO      28
`define DCRC_DSTORD_BIT    27
`define DCRC_REFL_BIT      24
`define DCRC_LEN_HI        12
`define DCRC_LEN_LO        8
`define DCRC_EN_BIT        7
`define DCRC_APP_BIT       6
`define DCRC_TYP_BIT       5
`define DCRC_CH_HI         2
`define DCRC_CH_LO         0

// reset values
`define DCRC_RST_DATA      32'h0000_0000
`define DCRC_RST_TAPS      32'h0000_0000

// byte order selections
`define DCRC_ORD_KEEP      2'b00
`define DCRC_ORD_REV       2'b01
`define DCRC_ORD_HSWAP     2'b10
`define DCRC_ORD_BSWAP     2'b11

// axi response codes
`define DCRC_RESP_OKAY     2'b00
`define DCRC_RESP_SLVERR   2'b10

// widths and misc
`define DCRC_LEN_MAX       5'd31
`define DCRC_ONES32        32'hffff_ffff
`define DCRC_HALF_W        16
`endif

/* dcrc_byte_step.v */
// one byte of the programmable lfsr, eight bit steps
`timescale 1ns/1ps
`include "dcrc_defines.vh"
module dcrc_byte_step
(
    input  wire [31:0] i_state,
    input  wire [7:0]  i_byte,
    input  wire        i_use,
    input  wire [31:0] i_taps,
    input  wire [4:0]  i_len,
    input  wire        i_reflect,
    output reg  [31:0] o_state
);

    integer     k;
    integer     j;
    reg  [31:0] s;
    reg  [31:0] ns;
    reg  [31:0] mask;
    reg         din;
    reg         fb;

    // galois shift, msb of the active width feeds back
    always @*
    begin
        s    = i_state;
        ns   = 32'h0000_0000;
        din  = 1'b0;
        fb   = 1'b0;
        mask = `DCRC_ONES32 >> (`DCRC_LEN_MAX - i_len);
        for (k = 0; k < 8; k = k + 1)
        begin
            // reflected takes bit 0 first, otherwise bit 7 first
            din = i_reflect ? i_byte[k] : i_byte[7 - k];
            fb  = din ^ s[i_len];
            // a set tap xors feedback in, a clear tap just shifts
            ns[0] = i_taps[0] & fb;
            for (j = 1; j < 32; j = j + 1)
            begin
                ns[j] = s[j - 1] ^ (i_taps[j] & fb);
            end
            s = ns & mask;
        end
        o_state = i_use ? s : i_state;
    end

endmodule

/* dcrc_top.v */
// dma crc/checksum engine with axi4-lite register slave
//
// Overview of operation
// - byte order field: keep, reverse word, swap half-words, swap bytes in halves
// - write-order bit set sends reordered data to destination, else unaltered
// - bit-order bit set computes lsb first (reflected), clear msb first
// - polynomial length field holds length minus one, sets lfsr width
// - checksum mode ignores the polynomial length field
// - enable routes assigned channel through engine, else plain transfer
// - append mode swallows data and writes result to start address at block end
// - append clear passes data through engine to destination
// - with destination reordering on, append cannot be set; no unaligned use
// - algorithm bit set picks ip checksum, clear picks lfsr crc
// - channel field attaches engine to channel 0 through 7
// - writing the result register seeds the generator
// - reading the result register returns the running value
// - lfsr mode: result bits above polynomial length read zero
// - checksum mode: only low 16 bits used, upper 16 read zero
// - checksum mode: written value is held inverted and reads back unchanged
// - unused control bits ignore writes and read zero
// - set tap bit xors feedback into stage, clear bit shifts directly
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dcrc_defines.vh"
module dcrc_top
(
    input  wire        i_mclk,
    input  wire        i_rst,
    // axi4-lite slave
    input  wire [7:0]  i_s_awaddr,
    input  wire        i_s_awvalid,
    output wire        o_s_awready,
    input  wire [31:0] i_s_wdata,
    input  wire [3:0]  i_s_wstrb,
    input  wire        i_s_wvalid,
    output wire        o_s_wready,
    output reg  [1:0]  o_s_bresp,
    output reg         o_s_bvalid,
    input  wire        i_s_bready,
    input  wire [7:0]  i_s_araddr,
    input  wire        i_s_arvalid,
    output wire        o_s_arready,
    output reg  [31:0] o_s_rdata,
    output reg  [1:0]  o_s_rresp,
    output reg         o_s_rvalid,
    input  wire        i_s_rready,
    // source words read by the dma channel engine
    input  wire        i_src_valid,
    input  wire [2:0]  i_src_chan,
    input  wire [31:0] i_src_data,
    input  wire [3:0]  i_src_be,
    output wire        o_src_ready,
    // block completion of a channel
    input  wire        i_block_done,
    input  wire [2:0]  i_block_chan,
    // destination words back to the channel engine
    output reg         o_dst_valid,
    output reg  [2:0]  o_dst_chan,
    output reg  [31:0] o_dst_data,
    output reg  [3:0]  o_dst_be,
    output reg         o_dst_to_start,
    input  wire        i_dst_ready
);

    // control fields
    reg  [1:0]  byte_reorder_sel_q;
    reg         dest_reorder_en_q;
    reg         reflect_sel_q;
    reg  [4:0]  poly_len_minus_one_q;
    reg         engine_enable_q;
    reg         append_result_mode_q;
    reg         algorithm_select_q;
    reg  [2:0]  attached_channel_sel_q;
    reg  [31:0] crc_feedback_taps_q;
    reg  [31:0] lfsr_q;
    reg  [15:0] csum_q;
    reg         result_pend_q;

    // bus bookkeeping
    reg         aw_have_q;
    reg         w_have_q;
    reg  [7:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    wire [31:0] ctrl_rd;
    wire [31:0] data_rd;
    wire [31:0] len_mask;
    wire [31:0] reord;
    wire [3:0]  reord_be;
    wire        engaged;
    wire        take_src;
    wire        out_free;
    wire        do_write;
    wire [31:0] wmask;
    wire [31:0] lfsr_chain [0:4];

    // control register image, unused positions stay zero
    assign ctrl_rd = {2'b00,
                      byte_reorder_sel_q,
                      dest_reorder_en_q,
                      2'b00,
                      reflect_sel_q,
                      11'h000,
                      poly_len_minus_one_q,
                      engine_enable_q,
                      append_result_mode_q,
                      algorithm_select_q,
                      2'b00,
                      attached_channel_sel_q};

    // running result as software sees it
    assign len_mask = `DCRC_ONES32 >> (`DCRC_LEN_MAX - poly_len_minus_one_q);
    assign data_rd  = algorithm_select_q ?
                      {16'h0000, ~csum_q} :
                      (lfsr_q & len_mask);

    // source reordering, word-wide; byte enables follow their bytes
    assign reord =
        (byte_reorder_sel_q == `DCRC_ORD_REV) ?
            {i_src_data[7:0], i_src_data[15:8],
             i_src_data[23:16], i_src_data[31:24]} :
        (byte_reorder_sel_q == `DCRC_ORD_HSWAP) ?
            {i_src_data[15:0], i_src_data[31:16]} :
        (byte_reorder_sel_q == `DCRC_ORD_BSWAP) ?
            {i_src_data[23:16], i_src_data[31:24],
             i_src_data[7:0], i_src_data[15:8]} :
            i_src_data;
    assign reord_be =
        (byte_reorder_sel_q == `DCRC_ORD_REV) ?
            {i_src_be[0], i_src_be[1], i_src_be[2], i_src_be[3]} :
        (byte_reorder_sel_q == `DCRC_ORD_HSWAP) ?
            {i_src_be[1:0], i_src_be[3:2]} :
        (byte_reorder_sel_q == `DCRC_ORD_BSWAP) ?
            {i_src_be[2], i_src_be[3], i_src_be[0], i_src_be[1]} :
            i_src_be;

    // only the attached channel sees the engine
    assign engaged  = engine_enable_q &&
                      (i_src_chan == attached_channel_sel_q);
    // one output register; a pending result holds the source off
    assign out_free    = ~o_dst_valid | i_dst_ready;
    assign o_src_ready = out_free & ~result_pend_q;
    assign take_src    = i_src_valid & o_src_ready;

    // lfsr bytes in ascending lane order after reordering
    assign lfsr_chain[0] = lfsr_q;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_lane
            dcrc_byte_step u_step
            (
                .i_state   (lfsr_chain[g]),
                .i_byte    (reord[8*g+7:8*g]),
                .i_use     (reord_be[g]),
                .i_taps    (crc_feedback_taps_q),
                .i_len     (poly_len_minus_one_q),
                .i_reflect (reflect_sel_q),
                .o_state   (lfsr_chain[g+1])
            );
        end
    endgenerate

    // ones-complement sum of both half-words, missing bytes as zero
    wire [15:0] half_lo;
    wire [15:0] half_hi;
    wire [16:0] sum_a;
    wire [15:0] fold_a;
    wire [16:0] sum_b;
    wire [15:0] csum_next;
    assign half_lo   = {reord[15:8] & {8{reord_be[1]}},
                        reord[7:0] & {8{reord_be[0]}}};
    assign half_hi   = {reord[31:24] & {8{reord_be[3]}},
                        reord[23:16] & {8{reord_be[2]}}};
    assign sum_a     = {1'b0, csum_q} + {1'b0, half_lo};
    assign fold_a    = sum_a[15:0] + {15'h0000, sum_a[16]};
    assign sum_b     = {1'b0, fold_a} + {1'b0, half_hi};
    assign csum_next = sum_b[15:0] + {15'h0000, sum_b[16]};

    // axi4-lite: address and data taken in either order
    assign o_s_awready = ~aw_have_q & ~o_s_bvalid;
    assign o_s_wready  = ~w_have_q & ~o_s_bvalid;
    assign o_s_arready = ~o_s_rvalid;
    assign do_write    = aw_have_q & w_have_q & ~o_s_bvalid;
    assign wmask       = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                          {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // merged write values, strobe lanes over the current image
    wire [31:0] ctrl_w;
    wire [31:0] data_w;
    wire [31:0] taps_w;
    assign ctrl_w = (ctrl_rd & ~wmask) | (w_data_q & wmask);
    assign data_w = (data_rd & ~wmask) | (w_data_q & wmask);
    assign taps_w = (crc_feedback_taps_q & ~wmask) | (w_data_q & wmask);

    // write channel capture and response
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            aw_addr_q  <= 8'h00;
            w_data_q   <= 32'h0000_0000;
            w_strb_q   <= 4'h0;
            o_s_bvalid <= 1'b0;
            o_s_bresp  <= `DCRC_RESP_OKAY;
        end
        else
        begin
            if (i_s_awvalid && o_s_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_s_awaddr;
            end
            if (i_s_wvalid && o_s_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= i_s_wdata;
                w_strb_q <= i_s_wstrb;
            end
            if (do_write)
            begin
                aw_have_q  <= 1'b0;
                w_have_q   <= 1'b0;
                o_s_bvalid <= 1'b1;
                // unmapped addresses answer with a slave error
                if (aw_addr_q == `DCRC_OFF_CTRL ||
                    aw_addr_q == `DCRC_OFF_DATA ||
                    aw_addr_q == `DCRC_OFF_TAPS)
                    o_s_bresp <= `DCRC_RESP_OKAY;
                else
                    o_s_bresp <= `DCRC_RESP_SLVERR;
            end
            else if (o_s_bvalid && i_s_bready)
            begin
                o_s_bvalid <= 1'b0;
            end
        end
    end

    // read channel, data registered one cycle after address
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_s_rvalid <= 1'b0;
            o_s_rdata  <= 32'h0000_0000;
            o_s_rresp  <= `DCRC_RESP_OKAY;
        end
        else if (i_s_arvalid && o_s_arready)
        begin
            o_s_rvalid <= 1'b1;
            o_s_rresp  <= `DCRC_RESP_OKAY;
            case (i_s_araddr)
                `DCRC_OFF_CTRL: o_s_rdata <= ctrl_rd;
                `DCRC_OFF_DATA: o_s_rdata <= data_rd;
                `DCRC_OFF_TAPS: o_s_rdata <= crc_feedback_taps_q;
                default:
                begin
                    o_s_rdata <= 32'h0000_0000;
                    o_s_rresp <= `DCRC_RESP_SLVERR;
                end
            endcase
        end
        else if (o_s_rvalid && i_s_rready)
        begin
            o_s_rvalid <= 1'b0;
        end
    end

    // control and tap registers
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            byte_reorder_sel_q     <= 2'b00;
            dest_reorder_en_q      <= 1'b0;
            reflect_sel_q          <= 1'b0;
            poly_len_minus_one_q   <= 5'h00;
            engine_enable_q        <= 1'b0;
            append_result_mode_q   <= 1'b0;
            algorithm_select_q     <= 1'b0;
            attached_channel_sel_q <= 3'h0;
            crc_feedback_taps_q    <= `DCRC_RST_TAPS;
        end
        else if (do_write && aw_addr_q == `DCRC_OFF_CTRL)
        begin
            byte_reorder_sel_q   <= ctrl_w[`DCRC_ORDER_HI:`DCRC_ORDER_LO];
            dest_reorder_en_q    <= ctrl_w[`DCRC_DSTORD_BIT];
            reflect_sel_q        <= ctrl_w[`DCRC_REFL_BIT];
            poly_len_minus_one_q <= ctrl_w[`DCRC_LEN_HI:`DCRC_LEN_LO];
            engine_enable_q      <= ctrl_w[`DCRC_EN_BIT];
            // append is refused while destination reordering is on
            append_result_mode_q <= ctrl_w[`DCRC_APP_BIT] &
                                    ~ctrl_w[`DCRC_DSTORD_BIT];
            algorithm_select_q   <= ctrl_w[`DCRC_TYP_BIT];
            attached_channel_sel_q <= ctrl_w[`DCRC_CH_HI:`DCRC_CH_LO];
        end
        else if (do_write && aw_addr_q == `DCRC_OFF_TAPS)
        begin
            crc_feedback_taps_q <= taps_w;
        end
    end

    // generator state: a software seed takes precedence over data
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            lfsr_q <= `DCRC_RST_DATA;
            csum_q <= 16'h0000;
        end
        else if (do_write && aw_addr_q == `DCRC_OFF_DATA)
        begin
            if (algorithm_select_q)
                csum_q <= ~data_w[`DCRC_HALF_W-1:0];
            else
                lfsr_q <= data_w;
        end
        else if (take_src && engaged)
        begin
            if (algorithm_select_q)
                csum_q <= csum_next;
            else
                lfsr_q <= lfsr_chain[4];
        end
    end

    // destination output: pass-through, swallow, or appended result
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_dst_valid    <= 1'b0;
            o_dst_chan     <= 3'h0;
            o_dst_data     <= 32'h0000_0000;
            o_dst_be       <= 4'h0;
            o_dst_to_start <= 1'b0;
            result_pend_q  <= 1'b0;
        end
        else
        begin
            if (out_free)
            begin
                o_dst_valid    <= 1'b0;
                o_dst_to_start <= 1'b0;
                if (result_pend_q)
                begin
                    result_pend_q  <= 1'b0;
                    o_dst_valid    <= 1'b1;
                    o_dst_chan     <= attached_channel_sel_q;
                    o_dst_data     <= data_rd;
                    o_dst_be       <= 4'hf;
                    o_dst_to_start <= 1'b1;
                end
                else if (take_src &&
                         !(engaged && append_result_mode_q))
                begin
                    o_dst_valid <= 1'b1;
                    o_dst_chan  <= i_src_chan;
                    // reordered only when engaged and write-order set
                    if (engaged && dest_reorder_en_q)
                    begin
                        o_dst_data <= reord;
                        o_dst_be   <= reord_be;
                    end
                    else
                    begin
                        o_dst_data <= i_src_data;
                        o_dst_be   <= i_src_be;
                    end
                end
            end
            // block end queues the result; stands last so a new set wins
            if (i_block_done && engine_enable_q &&
                append_result_mode_q &&
                i_block_chan == attached_channel_sel_q)
                result_pend_q <= 1'b1;
        end
    end

endmodule

/* dcrc_checker.sv */
// port-level assertions for the crc and checksum engine
`timescale 1ns/1ps
module dcrc_checker
(
    input wire        i_mclk,
    input wire        i_rst,
    input wire [7:0]  i_s_araddr,
    input wire        i_s_arvalid,
    input wire        o_s_arready,
    input wire        o_s_awready,
    input wire        o_s_wready,
    input wire [1:0]  o_s_bresp,
    input wire        o_s_bvalid,
    input wire        i_s_bready,
    input wire [31:0] o_s_rdata,
    input wire [1:0]  o_s_rresp,
    input wire        o_s_rvalid,
    input wire        i_s_rready,
    input wire        i_src_valid,
    input wire        o_src_ready,
    input wire        o_dst_valid,
    input wire [31:0] o_dst_data,
    input wire        o_dst_to_start,
    input wire        i_dst_ready
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // destination word must not move while the far side stalls
    property p_dst_hold;
        o_dst_valid && !i_dst_ready |=> o_dst_valid && $stable(o_dst_data)
            && $stable(o_dst_to_start);
    endproperty
    a_dst_hold: assert property (p_dst_hold) else $error("dst word moved");
    property p_src_block;
        o_dst_valid && !i_dst_ready |-> !o_src_ready;
    endproperty
    a_src_block: assert property (p_src_block) else $error("src overrun");
    // a new destination word has a source word or a result behind it
    property p_dst_cause;
        $rose(o_dst_valid) |-> $past(i_src_valid && o_src_ready) || o_dst_to_start;
    endproperty
    a_dst_cause: assert property (p_dst_cause) else $error("dst from nothing");
    property p_start_flag;
        o_dst_to_start |-> o_dst_valid;
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("stray flag");
    property p_b_hold;
        o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
    property p_r_hold;
        o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata moved");
    property p_r_answer;
        i_s_arvalid && o_s_arready |=> o_s_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("no read reply");
    property p_w_block;
        o_s_bvalid |-> !o_s_awready && !o_s_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write overrun");
    // unmapped places above 08 answer with an error and no data
    property p_unmapped;
        i_s_arvalid && o_s_arready && i_s_araddr > 8'h08
            |=> o_s_rresp == 2'b10 && o_s_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad unmapped");

    c_append: cover property (o_dst_valid && o_dst_to_start && i_dst_ready);
    c_stall: cover property (o_dst_valid && !i_dst_ready);
    c_rderr: cover property (o_s_rvalid && o_s_rresp == 2'b10);
endmodule

bind dcrc_top dcrc_checker i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_s_araddr(i_s_araddr), .i_s_arvalid(i_s_arvalid),
    .o_s_arready(o_s_arready), .o_s_awready(o_s_awready),
    .o_s_wready(o_s_wready), .o_s_bresp(o_s_bresp), .o_s_bvalid(o_s_bvalid),
    .i_s_bready(i_s_bready), .o_s_rdata(o_s_rdata), .o_s_rresp(o_s_rresp),
    .o_s_rvalid(o_s_rvalid), .i_s_rready(i_s_rready),
    .i_src_valid(i_src_valid), .o_src_ready(o_src_ready),
    .o_dst_valid(o_dst_valid), .o_dst_data(o_dst_data),
    .o_dst_to_start(o_dst_to_start), .i_dst_ready(i_dst_ready));

/* dcrc_chan_model.sv */
// model of the dma channel engine that feeds and drains the crc engine
`timescale 1ns/1ps
module dcrc_chan_model
(
    input  wire        i_mclk,
    output logic       o_src_valid,
    output logic [2:0] o_src_chan,
    output wire [31:0] o_src_data,
    output logic [3:0] o_src_be,
    input  wire        i_src_ready,
    output logic       o_block_done,
    output logic [2:0] o_block_chan,
    input  wire        i_dst_valid,
    input  wire [2:0]  i_dst_chan,
    input  wire [31:0] i_dst_data,
    input  wire [3:0]  i_dst_be,
    input  wire        i_dst_to_start,
    output logic       o_dst_ready
);
    logic [31:0] data_q;
    logic [31:0] junk_q;
    logic [39:0] got[$];

    initial
    begin
        o_src_valid = 1'b0; o_src_chan = 3'h0; o_src_be = 4'hf;
        o_block_done = 1'b0; o_block_chan = 3'h0; o_dst_ready = 1'b0;
        data_q = 32'h0; junk_q = 32'h1;
    end
    // idle data lines churn so a late sample never looks valid
    assign o_src_data = o_src_valid ? data_q : junk_q;
    // random stalls on the destination side
    always @(posedge i_mclk)
    begin
        junk_q <= {junk_q[30:0], ~junk_q[31]};
        o_dst_ready <= ($urandom % 4) != 0;
    end
    // sampled mid-cycle: the coming edge's handshake is already decided
    always @(negedge i_mclk)
        if (i_dst_valid && o_dst_ready)
            got.push_back({i_dst_to_start, i_dst_chan, i_dst_be, i_dst_data});

    // one whole aligned word, held until taken
    task send(input logic [2:0] c, input logic [31:0] d);
        @(posedge i_mclk);
        o_src_valid <= 1'b1; o_src_chan <= c; data_q <= d;
        o_src_be <= 4'hf;
        do @(negedge i_mclk); while (!i_src_ready);
        @(posedge i_mclk);
        o_src_valid <= 1'b0;
    endtask
    task finish(input logic [2:0] c);
        @(posedge i_mclk);
        o_block_done <= 1'b1; o_block_chan <= c;
        @(posedge i_mclk);
        o_block_done <= 1'b0;
    endtask
endmodule

/* dcrc_top_tb.sv */
// self-checking bench for the crc and checksum engine
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module dcrc_top_tb;
    logic i_mclk = 0, i_rst = 1, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdt;
    wire aw_r, w_r, bv, ar_r, rv, sv, srd, bd, dv, dts, drd;
    wire [1:0] br, rr;
    wire [2:0] sc, bc, dc;
    wire [31:0] rdata, sd, dd;
    wire [3:0] sb, db;
    int err_total = 0, check_count = 0, cyc = 0;
    logic [39:0] exq[$];

    always #5 i_mclk = ~i_mclk;
    dcrc_top i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_s_awaddr(awa),
        .i_s_awvalid(awv), .o_s_awready(aw_r), .i_s_wdata(wd),
        .i_s_wstrb(4'hf), .i_s_wvalid(wv), .o_s_wready(w_r), .o_s_bresp(br),
        .o_s_bvalid(bv), .i_s_bready(brd), .i_s_araddr(ara),
        .i_s_arvalid(arv), .o_s_arready(ar_r), .o_s_rdata(rdata),
        .o_s_rresp(rr), .o_s_rvalid(rv), .i_s_rready(rrd), .i_src_valid(sv),
        .i_src_chan(sc), .i_src_data(sd), .i_src_be(sb), .o_src_ready(srd),
        .i_block_done(bd), .i_block_chan(bc), .o_dst_valid(dv),
        .o_dst_chan(dc), .o_dst_data(dd), .o_dst_be(db),
        .o_dst_to_start(dts), .i_dst_ready(drd));
    dcrc_chan_model i_chan (.i_mclk(i_mclk), .o_src_valid(sv),
        .o_src_chan(sc), .o_src_data(sd), .o_src_be(sb), .i_src_ready(srd),
        .o_block_done(bd), .o_block_chan(bc), .i_dst_valid(dv),
        .i_dst_chan(dc), .i_dst_data(dd), .i_dst_to_start(dts), .i_dst_be(db),
        .o_dst_ready(drd));

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hang is cut short well above the expected run length
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test;
        end
    end

    // axi4-lite write; ready seen at negedge holds for the coming edge
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wdn, ta, tw;
        @(posedge i_mclk);
        awa <= a; awv <= 1; wd <= d; wv <= 1; brd <= 1; ad = 0; wdn = 0;
        while (!(ad && wdn))
        begin
            @(negedge i_mclk);
            ta = !ad && aw_r; tw = !wdn && w_r;
            @(posedge i_mclk);
            if (ta) begin awv <= 0; ad = 1; end
            if (tw) begin wv <= 0; wdn = 1; end
        end
        do @(negedge i_mclk); while (!bv);
        r = br;
        @(posedge i_mclk);
        brd <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_mclk);
        ara <= a; arv <= 1; rrd <= 1;
        do @(negedge i_mclk); while (!ar_r);
        @(posedge i_mclk);
        arv <= 0;
        do @(negedge i_mclk); while (!rv);
        d = rdata; r = rr;
        @(posedge i_mclk);
        rrd <= 0;
    endtask

    function automatic logic [31:0] mk(input logic [4:0] n);
        return (32'h1 << ({1'b0, n} + 6'd1)) - 32'h1;
    endfunction
    function automatic logic [31:0] ordr(input logic [31:0] d, input [1:0] o);
        case (o)
            2'b01: return {d[7:0], d[15:8], d[23:16], d[31:24]};
            2'b10: return {d[15:0], d[31:16]};
            2'b11: return {d[23:16], d[31:24], d[7:0], d[15:8]};
            default: return d;
        endcase
    endfunction
    // galois step per bit, lane 0 first, reflect picks bit 0 first
    function automatic logic [31:0] lstep(input logic [31:0] s,
        input logic [7:0] b, input logic [31:0] t, input logic [4:0] n,
        input logic rf);
        logic fb;
        for (int i = 0; i < 8; i++)
        begin
            fb = (rf ? b[i] : b[7-i]) ^ s[n];
            for (int j = 31; j > 0; j--)
                s[j] = s[j-1] ^ (t[j] & fb);
            s[0] = t[0] & fb;
            s = s & mk(n);
        end
        return s;
    endfunction
    function automatic logic [15:0] oadd(input logic [15:0] a, input [15:0] b);
        logic [16:0] s;
        s = a + b;
        return s[15:0] + s[16];
    endfunction

    task automatic round(input int r);
        logic [1:0] bo, rs; logic wb, rf, app, typ, en;
        logic [4:0] ln; logic [2:0] ch; logic [15:0] cs;
        logic [31:0] tp, sdv, d, w, st, res, got; logic [39:0] g, e; int n;
        bo = $urandom; wb = $urandom; rf = $urandom; typ = $urandom;
        app = $urandom; en = ($urandom % 4) != 0; ln = $urandom;
        ch = $urandom; tp = $urandom; sdv = $urandom; n = 1 + $urandom % 4;
        if (r < 4) begin bo = r[1:0]; wb = 1; en = 1; end
        if (r == 4) ln = 5'd0;
        if (r == 5) ln = 5'd31;
        if (r == 6 || r == 7) begin app = 1; en = 1; wb = 0; typ = r[0]; end
        if (wb) app = 0;
        wr(8'h08, tp, rs);
        wr(8'h00, {2'b0, bo, wb, 2'b0, rf, 11'h0, ln, en, app, typ, 2'b0, ch},
            rs);
        wr(8'h04, sdv, rs);
        rd(8'h04, got, rs);
        `CHK(got, typ ? {16'h0, sdv[15:0]} : sdv & mk(ln))
        st = sdv; cs = ~sdv[15:0];
        for (int i = 0; i < n; i++)
        begin
            d = $urandom;
            if (i == 1)
            begin
                i_chan.send(ch + 3'd1, ~d);
                exq.push_back({1'b0, ch + 3'd1, 4'hf, ~d});
            end
            i_chan.send(ch, d);
            w = ordr(d, bo);
            if (en)
            begin
                for (int k = 0; k < 4; k++)
                    st = lstep(st, w[8*k +: 8], tp, ln, rf);
                cs = oadd(oadd(cs, w[15:0]), w[31:16]);
            end
            if (!(en && app))
                exq.push_back({1'b0, ch, 4'hf, (en && wb) ? w : d});
        end
        res = typ ? {16'h0, ~cs} : st & mk(ln);
        if (en && app)
        begin
            i_chan.finish(ch);
            exq.push_back({1'b1, ch, 4'hf, res});
        end
        while (i_chan.got.size() < exq.size())
            @(posedge i_mclk);
        while (exq.size() > 0)
        begin
            g = i_chan.got.pop_front();
            e = exq.pop_front();
            `CHK(g, e)
        end
        rd(8'h04, got, rs);
        `CHK(got, res)
        $display("round %0d done", r);
    endtask

    initial
    begin
        logic [1:0] rs;
        cyc = $urandom(32'h14ad655a);
        cyc = 0;
        repeat (12) @(posedge i_mclk);
        i_rst <= 0;
        rd(8'h00, rdt, rs);
        `CHK({rs, rdt}, {2'b00, 32'h0})
        rd(8'h08, rdt, rs);
        `CHK(rdt, 32'h0)
        wr(8'h00, 32'hffff_ffff, rs);
        `CHK(rs, 2'b00)
        rd(8'h00, rdt, rs);
        `CHK(rdt, 32'h3900_1fa7)
        rd(8'h0c, rdt, rs);
        `CHK({rs, rdt}, {2'b10, 32'h0})
        wr(8'h10, 32'h1234_5678, rs);
        `CHK(rs, 2'b10)
        $display("register test done");
        for (int r = 0; r < 24; r++)
            round(r);
        stop_test;
    end
endmodule
